// file: sld_pkg.sv
// Purpose: Shared constants and types of the segment latch driver
// Assumes: 200 MHz system clock
// Notes:   Fonts are {g,f,e,d,c,b,a}, segment a in bit 0
package sld_pkg;

	// =========================================================
	// Geometry
	localparam int unsigned DIGITS   = 4;
	localparam int unsigned SEG_BITS = 7;
	localparam int unsigned CODE_W   = 4;

	// =========================================================
	// Timing
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned BP_INT_HZ     = 150;
	localparam int unsigned BP_INT_HALF   = CLK_HZ / (2 * BP_INT_HZ);
	localparam int unsigned BP_EXT_HALF   = 512;
	localparam int unsigned BP_CNT_W      = 20;

	// =========================================================
	// Reset values and special codes
	localparam logic [SEG_BITS-1:0] SEG_RST   = 7'h00;
	localparam logic [SEG_BITS-1:0] SEG_BLANK = 7'h00;
	localparam logic [CODE_W-1:0]   CODE_ALL  = 4'hF;
	localparam logic [CODE_W-1:0]   CODE_DEC  = 4'h9;

	// =========================================================
	// Backplane source
	typedef enum logic [2:0] {
		BP_INT = 3'h1,
		BP_EXT = 3'h2,
		BP_SLV = 3'h4
	} sld_bp_src_t;

	// Digit select pair to latch index: 00->4th, 01->3rd, 10->2nd, 11->1st
	function automatic logic [1:0] sld_digit_index(input logic [1:0] sel);
		sld_digit_index = 2'h3 - sel;
	endfunction : sld_digit_index

endpackage : sld_pkg

// file: sld_font_decode.sv
// Purpose: Four-bit code to seven-segment decode, two fonts
// Assumes: Combinational, used by the latch driver
// Notes:   Alternate font differs only above nine
module sld_font_decode
	import sld_pkg::*;
(
	input  wire logic                i_clk,      // Clock for checks only
	input  wire logic                i_rstn,     // Reset for checks only
	input  wire logic [CODE_W-1:0]   i_code,     // Character code
	input  wire logic                i_font_alt, // High selects alternate font
	output logic      [SEG_BITS-1:0] o_seg       // Decoded segments
);

	logic [SEG_BITS-1:0] seg_hex;
	logic [SEG_BITS-1:0] seg_alt;

	always_comb begin
		unique case (i_code)
			4'h0: seg_hex = 7'h3F;
			4'h1: seg_hex = 7'h06;
			4'h2: seg_hex = 7'h5B;
			4'h3: seg_hex = 7'h4F;
			4'h4: seg_hex = 7'h66;
			4'h5: seg_hex = 7'h6D;
			4'h6: seg_hex = 7'h7D;
			4'h7: seg_hex = 7'h07;
			4'h8: seg_hex = 7'h7F;
			4'h9: seg_hex = 7'h6F;
			4'hA: seg_hex = 7'h77;
			4'hB: seg_hex = 7'h7C;
			4'hC: seg_hex = 7'h39;
			4'hD: seg_hex = 7'h5E;
			4'hE: seg_hex = 7'h79;
			4'hF: seg_hex = 7'h71;
		endcase
	end

	always_comb begin
		unique case (i_code)
			4'hA:    seg_alt = 7'h40;
			4'hB:    seg_alt = 7'h79;
			4'hC:    seg_alt = 7'h76;
			4'hD:    seg_alt = 7'h38;
			4'hE:    seg_alt = 7'h73;
			4'hF:    seg_alt = SEG_BLANK; // RQ7
			default: seg_alt = seg_hex;   // RQ15
		endcase
	end

	assign o_seg = i_font_alt ? seg_alt : seg_hex;

	// =========================================================
	// Checks
	property p_alt_blank;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_font_alt && i_code == CODE_ALL) |-> (o_seg == SEG_BLANK);
	endproperty
	a_alt_blank: assert property (p_alt_blank) else $error("alt font all ones not blank"); // RQ7

	property p_fonts_agree;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_code <= CODE_DEC) |-> (seg_alt == seg_hex && seg_hex != SEG_BLANK);
	endproperty
	a_fonts_agree: assert property (p_fonts_agree) else $error("fonts differ on decimal code"); // RQ15

endmodule : sld_font_decode

// file: sld_latch_driver.sv
// Purpose: Four-digit segment latches, load ports and backplane timing
// Assumes: All pins synchronous to i_clk; one variant chosen by i_uport_mode
// Notes:   Segments and backplane leave on flops, aligned to one edge
//
// Operation
// RQ1 - One high digit strobe loads that digit only; none high changes nothing.
// RQ2 - All four strobes high load the same character into every digit.
// RQ3 - Free-running internal backplane near 150 Hz with oscillator pin open.
// RQ4 - Externally driven oscillator pin divides down to the backplane.
// RQ5 - Grounded oscillator pin makes backplane an input followed from a master.
// RQ6 - Host loads code ending 11 to use high bits as two flags.
// RQ7 - Alternate font shows all segments off for code F.
// RQ8 - Releasing both low chip selects stores code into selected digit.
// RQ9 - Host takes three-flag codes from a lookup table per font.
// RQ10 - Selects 00, 01, 10, 11 choose digits four, three, two, one.
// RQ11 - Without a chip select release, all digit latches hold.
// RQ12 - Strobe rise latches; held strobe relatches each backplane edge; low holds.
// RQ13 - Chip selects both low are transparent; release fires one write pulse.
// RQ14 - Segment output is backplane when off, inverted backplane when on.
// RQ15 - Both fonts decode zero to nine the same.
module sld_latch_driver
	import sld_pkg::*;
#(
	parameter int unsigned INT_HALF = BP_INT_HALF, // Cycles per internal half period
	parameter int unsigned EXT_HALF = BP_EXT_HALF  // Oscillator rising edges per half period
) (
	input  wire logic                       i_clk,              // 200 MHz clock
	input  wire logic                       i_rstn,             // Sync reset, active low
	input  wire logic [CODE_W-1:0]          i_code,             // Code bits 3..0
	input  wire logic                       i_font_alt,         // Alternate font variant
	input  wire logic                       i_uport_mode,       // Processor port variant
	input  wire logic                       i_digit_strobe_one,   // Strobe, first digit
	input  wire logic                       i_digit_strobe_two,   // Strobe, second digit
	input  wire logic                       i_digit_strobe_three, // Strobe, third digit
	input  wire logic                       i_digit_strobe_four,  // Strobe, fourth digit
	input  wire logic                       i_digit_select_low,   // Digit select, low bit
	input  wire logic                       i_digit_select_high,  // Digit select, high bit
	input  wire logic                       i_chip_select_a_n,    // Chip select A, low
	input  wire logic                       i_chip_select_b_n,    // Chip select B, low
	input  wire logic                       i_osc_grounded,     // Oscillator pin tied low
	input  wire logic                       i_osc_driven,       // Oscillator pin driven
	input  wire logic                       i_osc_in,           // Oscillator pin level
	input  wire logic                       i_backplane,        // Backplane pin input
	output logic                            o_backplane,        // Backplane pin output
	output logic                            o_backplane_oe,     // Backplane drive enable
	output logic [DIGITS*SEG_BITS-1:0]      o_segments          // Segment pins, digit 1 low
);

	// =========================================================
	// Backplane source and generation
	sld_bp_src_t         src;
	sld_bp_src_t         next_src;
	logic                bp;
	logic                next_bp;
	logic                bp_toggle;
	logic                osc_q;
	logic [BP_CNT_W-1:0] cnt;

	always_comb begin
		if (i_osc_grounded) begin
			next_src = BP_SLV;
		end else if (i_osc_driven) begin
			next_src = BP_EXT;
		end else begin
			next_src = BP_INT;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			src <= BP_INT;
		end else begin
			src <= next_src;
		end
	end

	always_comb begin
		next_bp = bp;
		unique case (src)
			BP_INT: begin
				if (cnt == BP_CNT_W'(INT_HALF - 1)) next_bp = ~bp; // RQ3
			end
			BP_EXT: begin
				if (i_osc_in && !osc_q && cnt == BP_CNT_W'(EXT_HALF - 1)) next_bp = ~bp; // RQ4
			end
			BP_SLV: begin
				next_bp = i_backplane; // RQ5
			end
			default: begin
				next_bp = bp;
			end
		endcase
	end

	assign bp_toggle = next_bp != bp;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt   <= '0;
			osc_q <= 1'b0;
			bp    <= 1'b0;
		end else begin
			osc_q <= i_osc_in;
			bp    <= next_bp;
			if (src != next_src || bp_toggle || src == BP_SLV) begin
				cnt <= '0;
			end else if (src == BP_INT || (i_osc_in && !osc_q)) begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	// =========================================================
	// Processor port input latch and one-shot
	logic [CODE_W-1:0] hold_code;
	logic [1:0]        hold_sel;
	logic              cs_low;
	logic              cs_was_low;
	logic              fire;

	assign cs_low = !i_chip_select_a_n && !i_chip_select_b_n;
	assign fire   = i_uport_mode && cs_was_low && !cs_low; // RQ8 RQ13

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			hold_code  <= '0;
			hold_sel   <= '0;
			cs_was_low <= 1'b0;
		end else begin
			cs_was_low <= cs_low;
			if (cs_low) begin
				hold_code <= i_code; // RQ13
				hold_sel  <= {i_digit_select_high, i_digit_select_low};
			end
		end
	end

	// =========================================================
	// Decode and digit latches
	logic [SEG_BITS-1:0] dec;
	logic [DIGITS-1:0]   strobe;
	logic [DIGITS-1:0]   strobe_q;
	logic [DIGITS-1:0]   load;
	logic [SEG_BITS-1:0] digit_latch [DIGITS];

	assign strobe = {i_digit_strobe_four, i_digit_strobe_three,
	                 i_digit_strobe_two, i_digit_strobe_one};

	sld_font_decode sld_font_decode_i (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_code     (i_uport_mode ? hold_code : i_code),
		.i_font_alt (i_font_alt),
		.o_seg      (dec)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			strobe_q <= '0;
		end else begin
			strobe_q <= i_uport_mode ? '0 : strobe;
		end
	end

	genvar d;
	generate
		for (d = 0; d < DIGITS; d++) begin : g_digit
			assign load[d] = i_uport_mode
				? (fire && sld_digit_index(hold_sel) == 2'(d))       // RQ10 RQ11
				: (strobe[d] && (!strobe_q[d] || bp_toggle));       // RQ1 RQ2 RQ12

			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					digit_latch[d] <= SEG_RST;
				end else if (load[d]) begin
					digit_latch[d] <= dec;
				end
			end

			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					o_segments[d*SEG_BITS +: SEG_BITS] <= '0;
				end else begin
					o_segments[d*SEG_BITS +: SEG_BITS] <= digit_latch[d] ^ {SEG_BITS{bp}}; // RQ14
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_backplane    <= 1'b0;
			o_backplane_oe <= 1'b1;
		end else begin
			o_backplane    <= bp;
			o_backplane_oe <= src != BP_SLV; // RQ5
		end
	end

	// =========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	property p_no_strobe;
		(!i_uport_mode && strobe == '0) |=> $stable(digit_latch[0]) && $stable(digit_latch[3]);
	endproperty
	a_no_strobe: assert property (p_no_strobe) else $error("latch moved with no strobe"); // RQ1

	property p_one_strobe;
		(!i_uport_mode && strobe == 4'h2 && !strobe_q[1])
			|=> digit_latch[1] == $past(dec) && $stable(digit_latch[0]);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("single strobe load wrong"); // RQ1

	property p_all_strobe;
		(!i_uport_mode && strobe == 4'hF && strobe_q == 4'h0)
			|=> digit_latch[0] == digit_latch[3] && digit_latch[2] == $past(dec);
	endproperty
	a_all_strobe: assert property (p_all_strobe) else $error("broadcast load wrong"); // RQ2

	property p_relatch;
		(!i_uport_mode && strobe[2] && strobe_q[2] && bp_toggle) |=> digit_latch[2] == $past(dec);
	endproperty
	a_relatch: assert property (p_relatch) else $error("no relatch on backplane edge"); // RQ12

	property p_int_toggle;
		(src == BP_INT && bp_toggle) |-> cnt == BP_CNT_W'(INT_HALF - 1);
	endproperty
	a_int_toggle: assert property (p_int_toggle) else $error("internal half period wrong"); // RQ3

	property p_ext_quiet;
		(src == BP_EXT && !(i_osc_in && !osc_q)) |=> $stable(bp);
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("backplane moved without osc edge"); // RQ4

	property p_slave;
		(src == BP_SLV) [*2] |=> !o_backplane_oe && o_backplane == $past(i_backplane, 2);
	endproperty
	a_slave: assert property (p_slave) else $error("slave backplane not followed"); // RQ5

	property p_uport_write;
		fire |=> digit_latch[sld_digit_index($past(hold_sel))] == $past(dec);
	endproperty
	a_uport_write: assert property (p_uport_write) else $error("port write missed digit"); // RQ8

	property p_uport_hold;
		(i_uport_mode && !fire) |=> $stable(digit_latch[1]) && $stable(digit_latch[2]);
	endproperty
	a_uport_hold: assert property (p_uport_hold) else $error("latch moved without release"); // RQ11

	property p_seg_drive;
		##1 o_segments[6:0] == ($past(digit_latch[0]) ^ {SEG_BITS{o_backplane}});
	endproperty
	a_seg_drive: assert property (p_seg_drive) else $error("segment drive not tied to backplane"); // RQ14

	c_strobe_load: cover property (!i_uport_mode && load[0]);
	c_uport_fire:  cover property (fire && hold_sel == 2'h0);
	c_bp_toggle:   cover property (src == BP_EXT && bp_toggle);
	c_slave:       cover property (src == BP_SLV && bp_toggle);

endmodule : sld_latch_driver

// file: sld_host_model.sv
// Purpose: Host that writes digit codes through strobes or the processor port
// Assumes: Drives its lines at the falling edge of i_clk
// Notes:   Code lines show the inverse code once a write is over
module sld_host_model
	import sld_pkg::*;
(
	input  wire logic          i_clk,    // System clock
	output logic [CODE_W-1:0]  o_code,   // Character code
	output logic [3:0]         o_strobe, // Strobes, bit 0 first digit
	output logic [1:0]         o_sel,    // Digit select {high,low}
	output logic               o_cs_a_n, // Chip select A
	output logic               o_cs_b_n  // Chip select B
);
	initial begin
		o_code   = 4'h0;
		o_strobe = 4'h0;
		o_sel    = 2'h0;
		o_cs_a_n = 1'b1;
		o_cs_b_n = 1'b1;
	end

	task automatic set_strobe(input logic [3:0] m, input logic [CODE_W-1:0] c);
		@(negedge i_clk);
		o_strobe = m;
		o_code   = c;
	endtask : set_strobe

	task automatic strobe_write(input logic [3:0] m, input logic [CODE_W-1:0] c);
		set_strobe(m, c);
		set_strobe(4'h0, ~c);
	endtask : strobe_write

	task automatic port_write(input logic [1:0] d, input logic [CODE_W-1:0] c,
			input logic tied);
		@(negedge i_clk);
		o_code   = c;
		o_sel    = 2'h3 - d;
		o_cs_a_n = 1'b0;
		o_cs_b_n = 1'b0;
		@(negedge i_clk);
		o_cs_a_n = 1'b1;
		o_cs_b_n = tied;
		o_sel    = ~o_sel;
		o_code   = ~c;
		@(negedge i_clk);
		o_cs_b_n = 1'b1;
	endtask : port_write
endmodule : sld_host_model

// file: tb_sld_latch_driver.sv
// Purpose: Self-checking bench of the segment latch driver
// Assumes: Small backplane dividers for a short run
// Notes:   Segments are compared after removing the backplane
module tb_sld_latch_driver
	import sld_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic                      clk = 0, rstn = 0, font_alt = 0, uport = 0;
	logic                      osc_gnd = 0, osc_drv = 0, osc_in = 0, bp_in = 0;
	logic [CODE_W-1:0]         code;
	logic [3:0]                strobe;
	logic [1:0]                sel;
	logic                      cs_a_n, cs_b_n, bp, bp_oe;
	logic [DIGITS*SEG_BITS-1:0] segs;
	logic [SEG_BITS-1:0]       exp_seg [4];
	logic [3:0]                masks [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
	logic [1:0]                h;
	logic [3:0]                c;
	// Three-flag codes, index is {f,e,a}
	logic [3:0]                flag3 [8] = '{4'h1, 4'h3, 4'hD, 4'h2, 4'h4, 4'h5, 4'hB, 4'h0};
	logic [6:0]                g;
	int                        errors = 0, cmp_count = 0, seed = 32'h1da2024e, n;

	always #2.5 clk = ~clk;
	always @(negedge clk) if (osc_drv) osc_in <= ~osc_in;

	sld_host_model sld_host_model_i (.i_clk(clk), .o_code(code), .o_strobe(strobe),
		.o_sel(sel), .o_cs_a_n(cs_a_n), .o_cs_b_n(cs_b_n));
	sld_latch_driver #(.INT_HALF(8), .EXT_HALF(2)) sld_latch_driver_i (
		.i_clk(clk), .i_rstn(rstn), .i_code(code), .i_font_alt(font_alt),
		.i_uport_mode(uport), .i_digit_strobe_one(strobe[0]),
		.i_digit_strobe_two(strobe[1]), .i_digit_strobe_three(strobe[2]),
		.i_digit_strobe_four(strobe[3]), .i_digit_select_low(sel[0]),
		.i_digit_select_high(sel[1]), .i_chip_select_a_n(cs_a_n),
		.i_chip_select_b_n(cs_b_n), .i_osc_grounded(osc_gnd), .i_osc_driven(osc_drv),
		.i_osc_in(osc_in), .i_backplane(bp_in), .o_backplane(bp),
		.o_backplane_oe(bp_oe), .o_segments(segs));

	function automatic logic [6:0] font(input logic [3:0] k, input logic alt);
		logic [127:0] hx = 128'h71795E397C776F7F077D6D664F5B063F;
		logic [47:0]  ax = 48'h007338767940;
		font = (alt && k > 4'h9) ? ax[(k - 4'hA) * 8 +: 7] : hx[k * 8 +: 7];
	endfunction : font

	task automatic check(input logic [6:0] seen, input logic [6:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("Error %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic complete_run();
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic check_all();
		repeat (4) @(negedge clk);
		for (int d = 0; d < 4; d++) check(segs[7*d +: 7] ^ {7{bp}}, exp_seg[d]);
	endtask : check_all

	task automatic do_reset();
		rstn = 1'b0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		exp_seg = '{default: SEG_RST};
		check({6'h0, bp_oe}, 7'h01);
		check_all();
	endtask : do_reset

	task automatic bp_edge(output int cyc);
		cyc = 0;
		for (logic b = bp; bp === b && cyc < 300; cyc++) @(negedge clk);
		if (cyc >= 300) begin
			errors++;
			complete_run();
		end
	endtask : bp_edge

	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		do_reset();
		for (int f = 0; f < 2; f++) begin
			font_alt = f[0];
			for (int i = 0; i < 40; i++) begin
				c = (i < 16) ? 4'(i) : 4'($random(seed));
				n = int'($unsigned($random(seed)) % 6);
				sld_host_model_i.strobe_write(masks[n], c);
				for (int d = 0; d < 4; d++) if (masks[n][d]) exp_seg[d] = font(c, f[0]);
				check_all();
			end
		end
		font_alt = 1'b0;
		sld_host_model_i.set_strobe(4'h1, 4'h2);
		sld_host_model_i.set_strobe(4'h1, 4'h5);
		bp_edge(n);
		bp_edge(n);
		exp_seg[0] = font(4'h5, 1'b0);
		check_all();
		sld_host_model_i.set_strobe(4'h0, 4'h9);
		repeat (40) @(negedge clk);
		check_all();
		for (int k = 0; k < 12; k++) begin
			c = (k < 8) ? flag3[k] : {2'(k), 2'h3};
			sld_host_model_i.strobe_write(4'h8, c);
			exp_seg[3] = font(c, 1'b0);
			check_all();
			g = segs[27:21] ^ {7{bp}};
			if (k < 8) check({4'h0, g[5:4], g[0]}, 7'(k));
			else check({5'h0, g[1], g[3]}, {5'h0, ~c[3], ~c[2]});
		end
		uport = 1'b1;
		do_reset();
		for (int i = 0; i < 32; i++) begin
			c = 4'($random(seed));
			sld_host_model_i.port_write(2'(i), c, i[2]);
			exp_seg[i % 4] = font(c, 1'b0);
			check_all();
		end
		sld_host_model_i.strobe_write(4'hF, 4'h8);
		check_all();
		uport = 1'b0;
		do_reset();
		bp_edge(n);
		bp_edge(n);
		check(7'(n), 7'd8);
		osc_drv = 1'b1;
		repeat (3) bp_edge(n);
		check(7'(n), 7'd4);
		osc_gnd = 1'b1;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			if (i >= 2) check({5'h0, bp_oe, bp}, {6'h0, h[1]});
			h = {h[0], 1'($random(seed))};
			bp_in = h[0];
		end
		complete_run();
	end
endmodule : tb_sld_latch_driver
